// ==== logic/fwa_defs.svh ====
// constants of the firmware area command interpreter
`ifndef FWA_DEFS_SVH
`define FWA_DEFS_SVH

`define FWA_OP_READ      8'h32
`define FWA_OP_WRITE     8'h33
`define FWA_BLK_BYTES    10'h0200
`define FWA_BLK_LAST     10'h01ff
`define FWA_ST_OK        8'h00
`define FWA_ST_NOPREP    8'h81
`define FWA_ST_BADADR    8'h82
`define FWA_ST_MEDIA     8'h83
`define FWA_ST_BADOP     8'h84
// older disk: head in [7:5], sector in [4:0]
`define FWA_HEAD_MSB     7
`define FWA_HEAD_LSB     5
`define FWA_SEC_MSB      4
`define FWA_SEC_LSB      0
`define FWA_OLD_SPT      8'h14
`define FWA_OLD_HEADS    8'h01
`define FWA_OLD_USR_CYL  8'h02
`define FWA_OLD_NCOPY    2'h2
// newer disk: 36 blocks over two tracks, copy in tracks 2-3
`define FWA_NEW_SPT      8'h12
`define FWA_NEW_LAST     8'h23
`define FWA_NEW_USR_TRK  8'h04
`define FWA_NEW_NCOPY    2'h2
// tape: firmware in track 1, boot block tripled in sectors 0-2
`define FWA_TAPE_TRK     8'h01
`define FWA_TAPE_LAST    8'h23
`define FWA_TAPE_BOOTS   2'h3
`define FWA_TAPE_USR_TRK 8'h02
`define FWA_DISK_HEADS   24'h00_0004

`endif

// ==== logic/fwa_pkg.sv ====
// types of the firmware area command interpreter
package fwa_pkg;

	typedef enum logic [1:0] {
		FWA_VAR_OLD  = 2'b00,
		FWA_VAR_NEW  = 2'b01,
		FWA_VAR_TAPE = 2'b10
	} fwa_var_type;

	typedef enum logic [2:0] {
		FWA_ST_IDLE  = 3'b000,
		FWA_ST_ADDR  = 3'b001,
		FWA_ST_WDATA = 3'b010,
		FWA_ST_MEDIA = 3'b011,
		FWA_ST_STAT  = 3'b100,
		FWA_ST_RDATA = 3'b101
	} fwa_state_type;

endpackage

// ==== logic/fwa_strm_if.sv ====
// byte stream between the interpreter and its result buffer
`timescale 1ns/100ps

interface fwa_strm_if #(
	parameter int WIDTH = 8
);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== logic/fwa_fifo.sv ====
// result byte fifo with valid and ready on both sides
`timescale 1ns/100ps

module fwa_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	fwa_strm_if.snk   in_s,
	fwa_strm_if.src   out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    wr_ptr_nxt;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-1:0]    rd_ptr_nxt;
	logic [AW:0]      cnt_r;
	logic [AW:0]      cnt_nxt;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_s.ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_s.valid = (cnt_r != '0);
	assign out_s.data  = mem[rd_ptr_r];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_comb begin
		wr_ptr_nxt = push ? inc(wr_ptr_r) : wr_ptr_r;
		rd_ptr_nxt = pop ? inc(rd_ptr_r) : rd_ptr_r;
		cnt_nxt    = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			cnt_r    <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_r] <= in_s.data;
		end
	end
endmodule

// ==== logic/fwa_map.sv ====
// firmware address byte to physical location, per media variant
`timescale 1ns/100ps
`include "fwa_defs.svh"

module fwa_map
	import fwa_pkg::*;
(
	input  wire fwa_var_type variant_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [1:0]  copy_i,
	output logic             valid_o,
	output logic [1:0]       ncopy_o,
	output logic [7:0]       trk_o,
	output logic [2:0]       head_o,
	output logic [7:0]       sec_o,
	output logic [7:0]       usr_trk_o
);
	logic [2:0] hd;
	logic [4:0] sc;

	assign hd = addr_i[`FWA_HEAD_MSB:`FWA_HEAD_LSB];
	assign sc = addr_i[`FWA_SEC_MSB:`FWA_SEC_LSB];

	// sector numbers pass straight through: no interleave, no sparing
	always_comb begin
		valid_o   = 1'b0;
		ncopy_o   = 2'h1;
		trk_o     = 8'h00;
		head_o    = 3'h0;
		sec_o     = 8'h00;
		usr_trk_o = 8'h00;
		unique case (variant_i)
			FWA_VAR_OLD: begin
				// copy 0 in cylinder 0, copy 1 in cylinder 1
				valid_o   = (8'(hd) <= `FWA_OLD_HEADS)
					&& (8'(sc) < `FWA_OLD_SPT);
				ncopy_o   = `FWA_OLD_NCOPY;
				trk_o     = 8'(copy_i);
				head_o    = hd;
				sec_o     = 8'(sc);
				usr_trk_o = `FWA_OLD_USR_CYL;
			end
			FWA_VAR_NEW: begin
				valid_o   = (addr_i <= `FWA_NEW_LAST);
				ncopy_o   = `FWA_NEW_NCOPY;
				if (addr_i < `FWA_NEW_SPT) begin
					trk_o = {5'h00, copy_i, 1'b0};
					sec_o = addr_i;
				end else begin
					trk_o = {5'h00, copy_i, 1'b1};
					sec_o = addr_i - `FWA_NEW_SPT;
				end
				usr_trk_o = `FWA_NEW_USR_TRK;
			end
			FWA_VAR_TAPE: begin
				valid_o   = (addr_i <= `FWA_TAPE_LAST);
				trk_o     = `FWA_TAPE_TRK;
				// block 0 is the boot block, kept in sectors 0..2
				if (addr_i == 8'h00) begin
					ncopy_o = `FWA_TAPE_BOOTS;
					sec_o   = 8'(copy_i);
				end else begin
					sec_o   = addr_i + 8'(`FWA_TAPE_BOOTS) - 8'h01;
				end
				usr_trk_o = `FWA_TAPE_USR_TRK;
			end
			default: begin
				valid_o = 1'b0;
			end
		endcase
	end
endmodule

// ==== logic/fwa_ctrl.sv ====
// firmware area read and write command interpreter
// Functional notes
// - firmware area stays outside user addressing and reported capacity
// - no interleave and no sparing on firmware accesses
// - older disk: 40 blocks in cylinder 0, copy in cylinder 1
// - older disk address byte: head in upper 3, sector lower 5
// - older disk blocks 0-19 head 0, 20-39 head 1
// - newer disk: 36 blocks, two tracks, copy, user from track 4
// - newer disk address byte is block number 0 to 35
// - tape firmware is first 38 sectors of track 1, 512 bytes each
// - tape keeps three identical boot block sectors
// - tape address byte is block number 0 to 35
// - read is 32h plus address, answered by 513 bytes
// - read result: status at offset 0, block data from offset 1
// - write is 33h, address, 512 bytes; answered by one status byte
`timescale 1ns/100ps
`include "fwa_defs.svh"

module fwa_ctrl
	import fwa_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [1:0]  variant_i,
	input  wire logic        prep_mode_i,
	input  wire logic [23:0] raw_blocks_i,
	output logic [23:0]      usable_blocks_o,
	output logic [7:0]       user_first_trk_o,
	input  wire logic        cmd_valid_i,
	output logic             cmd_ready_o,
	input  wire logic [7:0]  cmd_data_i,
	output logic             res_valid_o,
	input  wire logic        res_ready_i,
	output logic [7:0]       res_data_o,
	output logic             med_req_o,
	output logic             med_wr_o,
	output logic [7:0]       med_trk_o,
	output logic [2:0]       med_head_o,
	output logic [7:0]       med_sec_o,
	output logic             med_raw_o,
	input  wire logic        med_rstb_i,
	input  wire logic [7:0]  med_rdata_i,
	input  wire logic        med_wstb_i,
	output logic [7:0]       med_wdata_o,
	input  wire logic        med_done_i,
	input  wire logic        med_err_i
);
	// ==========================================================
	// variant strap synchroniser
	// ==========================================================
	logic [1:0]    var_s1_r;
	logic [1:0]    var_s2_r;
	fwa_var_type   variant;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			var_s1_r <= 2'b00;
			var_s2_r <= 2'b00;
		end else begin
			var_s1_r <= variant_i;
			var_s2_r <= var_s1_r;
		end
	end

	assign variant = fwa_var_type'(var_s2_r);

	// ==========================================================
	// state
	// ==========================================================
	fwa_state_type state_r;
	fwa_state_type state_nxt;
	logic [7:0]    op_r;
	logic [7:0]    op_nxt;
	logic [7:0]    addr_r;
	logic [7:0]    addr_nxt;
	logic [7:0]    stat_r;
	logic [7:0]    stat_nxt;
	logic [9:0]    idx_r;
	logic [9:0]    idx_nxt;
	logic [1:0]    copy_r;
	logic [1:0]    copy_nxt;
	logic          req_r;
	logic          req_nxt;
	logic [7:0]    wdata_r;
	logic [7:0]    wdata_nxt;
	logic [7:0]    blk [512];

	logic          map_valid;
	logic [1:0]    map_ncopy;
	logic [7:0]    map_trk;
	logic [2:0]    map_head;
	logic [7:0]    map_sec;
	logic [7:0]    usr_trk;
	logic [7:0]    pos_trk_r;
	logic [2:0]    pos_head_r;
	logic [7:0]    pos_sec_r;

	logic          take;
	logic          is_fw_op;
	logic          buf_wr;
	logic [7:0]    buf_wdata;

	fwa_strm_if #(.WIDTH(8)) push_s ();
	fwa_strm_if #(.WIDTH(8)) pop_s ();

	fwa_map u_map (
		.variant_i (variant),
		.addr_i    (addr_r),
		.copy_i    (copy_r),
		.valid_o   (map_valid),
		.ncopy_o   (map_ncopy),
		.trk_o     (map_trk),
		.head_o    (map_head),
		.sec_o     (map_sec),
		.usr_trk_o (usr_trk)
	);

	fwa_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.in_s    (push_s),
		.out_s   (pop_s)
	);

	function automatic logic last_byte(input logic [9:0] i);
		last_byte = (i == `FWA_BLK_LAST);
	endfunction

	// ==========================================================
	// user area boundary
	// ==========================================================
	// user blocks start past the firmware tracks; tape user blocks
	// are already counted from track 2 so nothing is subtracted
	logic [23:0] rsv_blocks;

	always_comb begin
		unique case (variant)
			FWA_VAR_OLD:
				rsv_blocks = 24'(`FWA_OLD_USR_CYL) * `FWA_DISK_HEADS
					* 24'(`FWA_OLD_SPT);
			FWA_VAR_NEW:
				rsv_blocks = 24'(`FWA_NEW_USR_TRK) * 24'(`FWA_NEW_SPT);
			default:
				rsv_blocks = 24'h00_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			usable_blocks_o  <= 24'h00_0000;
			user_first_trk_o <= 8'h00;
		end else begin
			usable_blocks_o  <= (raw_blocks_i > rsv_blocks)
				? raw_blocks_i - rsv_blocks : 24'h00_0000;
			user_first_trk_o <= usr_trk;
		end
	end

	// ==========================================================
	// host byte stream
	// ==========================================================
	assign cmd_ready_o = (state_r == FWA_ST_IDLE)
		|| (state_r == FWA_ST_ADDR) || (state_r == FWA_ST_WDATA);
	assign take        = cmd_valid_i && cmd_ready_o;
	assign is_fw_op    = (op_r == `FWA_OP_READ) || (op_r == `FWA_OP_WRITE);
	assign res_valid_o = pop_s.valid;
	assign res_data_o  = pop_s.data;
	assign pop_s.ready = res_ready_i;

	// rejected reads still return a full 513 bytes, data zeroed
	always_comb begin
		push_s.valid = 1'b0;
		push_s.data  = stat_r;
		if (state_r == FWA_ST_STAT) begin
			push_s.valid = 1'b1;
		end else if (state_r == FWA_ST_RDATA) begin
			push_s.valid = 1'b1;
			push_s.data  = (stat_r == `FWA_ST_OK) ? blk[idx_r[8:0]] : 8'h00;
		end
	end

	// ==========================================================
	// sequencer
	// ==========================================================
	always_comb begin
		state_nxt = state_r;
		op_nxt    = op_r;
		addr_nxt  = addr_r;
		stat_nxt  = stat_r;
		idx_nxt   = idx_r;
		copy_nxt  = copy_r;
		req_nxt   = req_r;
		buf_wr    = 1'b0;
		buf_wdata = cmd_data_i;
		unique case (state_r)
			FWA_ST_IDLE: begin
				if (take) begin
					op_nxt    = cmd_data_i;
					state_nxt = FWA_ST_ADDR;
				end
			end
			FWA_ST_ADDR: begin
				if (!is_fw_op) begin
					stat_nxt  = `FWA_ST_BADOP;
					state_nxt = FWA_ST_STAT;
				end else if (take) begin
					addr_nxt = cmd_data_i;
					idx_nxt  = 10'h000;
					copy_nxt = 2'h0;
					if (op_r == `FWA_OP_WRITE) begin
						state_nxt = FWA_ST_WDATA;
					end else begin
						state_nxt = FWA_ST_MEDIA;
					end
				end
			end
			FWA_ST_WDATA: begin
				if (take) begin
					buf_wr  = 1'b1;
					idx_nxt = idx_r + 10'h001;
					if (last_byte(idx_r)) begin
						idx_nxt   = 10'h000;
						state_nxt = FWA_ST_MEDIA;
					end
				end
			end
			FWA_ST_MEDIA: begin
				// a medium request is only started in prep mode
				if (!req_r && !prep_mode_i) begin
					stat_nxt  = `FWA_ST_NOPREP;
					state_nxt = FWA_ST_STAT;
				end else if (!req_r && !map_valid) begin
					stat_nxt  = `FWA_ST_BADADR;
					state_nxt = FWA_ST_STAT;
				end else if (!req_r) begin
					req_nxt  = 1'b1;
					stat_nxt = `FWA_ST_OK;
				end else begin
					if (med_rstb_i && op_r == `FWA_OP_READ) begin
						buf_wr    = 1'b1;
						buf_wdata = med_rdata_i;
						idx_nxt   = idx_r + 10'h001;
					end
					if (med_wstb_i && op_r == `FWA_OP_WRITE) begin
						idx_nxt = idx_r + 10'h001;
					end
					if (med_done_i) begin
						req_nxt = 1'b0;
						idx_nxt = 10'h000;
						if (med_err_i) begin
							stat_nxt  = `FWA_ST_MEDIA;
							state_nxt = FWA_ST_STAT;
						end else if (op_r == `FWA_OP_WRITE
							&& copy_r + 2'h1 < map_ncopy) begin
							// write every copy of the block in turn
							copy_nxt = copy_r + 2'h1;
						end else begin
							state_nxt = FWA_ST_STAT;
						end
					end
				end
			end
			FWA_ST_STAT: begin
				if (push_s.ready) begin
					idx_nxt = 10'h000;
					if (op_r == `FWA_OP_READ) begin
						state_nxt = FWA_ST_RDATA;
					end else begin
						state_nxt = FWA_ST_IDLE;
					end
				end
			end
			FWA_ST_RDATA: begin
				if (push_s.ready) begin
					idx_nxt = idx_r + 10'h001;
					if (last_byte(idx_r)) begin
						state_nxt = FWA_ST_IDLE;
					end
				end
			end
			default: begin
				state_nxt = FWA_ST_IDLE;
			end
		endcase
		wdata_nxt = blk[idx_nxt[8:0]];
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_r <= FWA_ST_IDLE;
			op_r    <= 8'h00;
			addr_r  <= 8'h00;
			stat_r  <= `FWA_ST_OK;
			idx_r   <= 10'h000;
			copy_r  <= 2'h0;
			req_r   <= 1'b0;
			wdata_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			op_r    <= op_nxt;
			addr_r  <= addr_nxt;
			stat_r  <= stat_nxt;
			idx_r   <= idx_nxt;
			copy_r  <= copy_nxt;
			req_r   <= req_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	// block buffer: one byte per cycle at most, no reset needed
	always_ff @(posedge clk_i) begin
		if (buf_wr) begin
			blk[idx_r[8:0]] <= buf_wdata;
		end
	end

	// ==========================================================
	// medium port
	// ==========================================================
	// location is latched so it stays still for the whole request
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pos_trk_r  <= 8'h00;
			pos_head_r <= 3'h0;
			pos_sec_r  <= 8'h00;
		end else if (!req_r) begin
			pos_trk_r  <= map_trk;
			pos_head_r <= map_head;
			pos_sec_r  <= map_sec;
		end
	end

	assign med_req_o   = req_r;
	assign med_wr_o    = req_r && (op_r == `FWA_OP_WRITE);
	assign med_trk_o   = pos_trk_r;
	assign med_head_o  = pos_head_r;
	assign med_sec_o   = pos_sec_r;
	assign med_raw_o   = 1'b1;
	assign med_wdata_o = wdata_r;
endmodule

// ==== dv/fwa_ctrl_properties.sv ====
// port assertions for the firmware area interpreter
`timescale 1ns/100ps

module fwa_ctrl_properties (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [1:0]  variant_i,
	input wire logic        prep_mode_i,
	input wire logic [23:0] raw_blocks_i,
	input wire logic [23:0] usable_blocks_o,
	input wire logic [7:0]  user_first_trk_o,
	input wire logic        res_valid_o,
	input wire logic        res_ready_i,
	input wire logic [7:0]  res_data_o,
	input wire logic        med_req_o,
	input wire logic        med_wr_o,
	input wire logic [7:0]  med_trk_o,
	input wire logic [2:0]  med_head_o,
	input wire logic [7:0]  med_sec_o,
	input wire logic        med_raw_o,
	input wire logic        med_done_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// ==========================================
	// capacity and layout
	// strap and capacity pass three flops, so wait for a calm strap
	sequence s_calm;
		(rst_n_i && $stable(variant_i) && $stable(raw_blocks_i))[*5];
	endsequence
	property p_cap_old;
		s_calm ##0 variant_i == 2'b00 |-> user_first_trk_o == 8'h02 &&
			usable_blocks_o == raw_blocks_i - 24'h00_00a0;
	endproperty
	a_cap_old: assert property (p_cap_old) else $error("old capacity");
	property p_cap_new;
		s_calm ##0 variant_i == 2'b01 |-> user_first_trk_o == 8'h04 &&
			usable_blocks_o == raw_blocks_i - 24'h00_0048;
	endproperty
	a_cap_new: assert property (p_cap_new) else $error("new capacity");
	property p_cap_tape;
		s_calm ##0 variant_i == 2'b10 |-> usable_blocks_o == raw_blocks_i;
	endproperty
	a_cap_tape: assert property (p_cap_tape) else $error("tape capacity");
	property p_loc_old;
		med_req_o && variant_i == 2'b00 |-> med_trk_o <= 8'h01 &&
			med_head_o <= 3'h1 && med_sec_o <= 8'h13;
	endproperty
	a_loc_old: assert property (p_loc_old) else $error("old location");
	property p_loc_new;
		med_req_o && variant_i == 2'b01 |-> med_trk_o <= 8'h03 &&
			med_head_o == 3'h0 && med_sec_o <= 8'h11;
	endproperty
	a_loc_new: assert property (p_loc_new) else $error("new location");
	property p_loc_tape;
		med_req_o && variant_i == 2'b10 |-> med_trk_o == 8'h01 &&
			med_head_o == 3'h0 && med_sec_o <= 8'h25;
	endproperty
	a_loc_tape: assert property (p_loc_tape) else $error("tape location");

	// ==========================================
	// medium and result handshakes
	property p_raw;
		med_raw_o;
	endproperty
	a_raw: assert property (p_raw) else $error("interleave applied");
	property p_req_hold;
		med_req_o && !med_done_i |=> med_req_o &&
			$stable({med_wr_o, med_trk_o, med_head_o, med_sec_o});
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("request moved");
	property p_req_drop;
		med_req_o && med_done_i |=> !med_req_o;
	endproperty
	a_req_drop: assert property (p_req_drop) else $error("request stuck");
	property p_prep;
		$rose(med_req_o) |-> prep_mode_i;
	endproperty
	a_prep: assert property (p_prep) else $error("medium without prep");
	property p_res_hold;
		res_valid_o && !res_ready_i |=> res_valid_o && $stable(res_data_o);
	endproperty
	a_res_hold: assert property (p_res_hold) else $error("result lost");

	c_wr: cover property (med_req_o && med_wr_o && med_done_i);
	c_rd: cover property (med_req_o && !med_wr_o && med_done_i);
	c_stall: cover property (res_valid_o && !res_ready_i ##1 res_ready_i);
endmodule

bind fwa_ctrl fwa_ctrl_properties u_props (.*);

// ==== dv/fwa_med_model.sv ====
// behavioural medium behind the interpreter
`timescale 1ns/100ps

module fwa_med_model (
	input  wire logic       clk_i,
	input  wire logic       req_i,
	input  wire logic       wr_i,
	input  wire logic [7:0] trk_i,
	input  wire logic [2:0] head_i,
	input  wire logic [7:0] sec_i,
	input  wire logic [7:0] wdata_i,
	output logic            rstb_o,
	output logic [7:0]      rdata_o,
	output logic            wstb_o,
	output logic            done_o,
	output logic            err_o
);
	logic [7:0]  mem [int];
	logic [18:0] loc_q [$];
	bit          err_on;
	int          i;
	int          key;

	initial begin
		{rstb_o, wstb_o, done_o, err_o, err_on} = '0;
		rdata_o = 8'h00;
		forever begin
			@(posedge clk_i);
			if (req_i) begin
				// location taken as given: physical, no remap
				loc_q.push_back({trk_i, head_i, sec_i});
				key = {trk_i, head_i, sec_i, 9'h000};
				repeat ($urandom_range(0, 6)) @(posedge clk_i);
				for (i = 0; i < 512; i++) begin
					wstb_o <= wr_i;
					rstb_o <= !wr_i;
					rdata_o <= mem.exists(key + i) ? mem[key + i] : 8'h00;
					@(posedge clk_i);
					if (wr_i)
						mem[key + i] = wdata_i;
					wstb_o <= 1'b0;
					rstb_o <= 1'b0;
					// idle data must not look like the last byte
					rdata_o <= ~rdata_o;
					@(posedge clk_i);
				end
				done_o <= 1'b1;
				err_o <= err_on;
				@(posedge clk_i);
				done_o <= 1'b0;
				err_o <= 1'b0;
			end
		end
	end
endmodule

// ==== dv/test_firmware_area_access.sv ====
// self-checking bench for the firmware area interpreter
`timescale 1ns/100ps

module test_firmware_area_access;
	logic        clk_i, rst_n_i, prep_mode_i, cmd_valid_i, res_ready_i;
	logic        cmd_ready_o, res_valid_o, med_req_o, med_wr_o, med_raw_o;
	logic        med_rstb_i, med_wstb_i, med_done_i, med_err_i;
	logic [1:0]  variant_i;
	logic [2:0]  med_head_o;
	logic [23:0] raw_blocks_i, usable_blocks_o;
	logic [7:0]  user_first_trk_o, cmd_data_i, res_data_o, med_trk_o;
	logic [7:0]  med_sec_o, med_rdata_i, med_wdata_o, adr;
	logic [7:0]  wq [$], rq [$];
	logic [23:0] rsv [3] = '{24'h00_00a0, 24'h00_0048, 24'h00_0000};
	logic [7:0]  fst [3] = '{8'h02, 8'h04, 8'h02};
	int          fails, num_checks, k, v, j, b, i, nc;

	fwa_ctrl dut (.*);
	fwa_med_model m (.clk_i(clk_i), .req_i(med_req_o), .wr_i(med_wr_o),
		.trk_i(med_trk_o), .head_i(med_head_o), .sec_i(med_sec_o),
		.wdata_i(med_wdata_o), .rstb_o(med_rstb_i), .rdata_o(med_rdata_i),
		.wstb_o(med_wstb_i), .done_o(med_done_i), .err_o(med_err_i));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// ==========================================
	// checking and host tasks
	task check(input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task finish_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task send(input logic [7:0] d);
		for (k = 0; k < 4000; k++) begin
			@(negedge clk_i);
			cmd_valid_i = 1'b1;
			cmd_data_i = d;
			#1;
			if (cmd_ready_o === 1'b1)
				break;
		end
		if (k == 4000) begin
			fails++;
			finish_test();
		end
		@(posedge clk_i);
	endtask

	task get(output logic [7:0] d);
		for (k = 0; k < 4000; k++) begin
			@(negedge clk_i);
			res_ready_i = ($urandom_range(0, 3) != 0);
			#1;
			if (res_ready_i && res_valid_o === 1'b1)
				break;
		end
		if (k == 4000) begin
			fails++;
			finish_test();
		end
		d = res_data_o;
		@(posedge clk_i);
		@(negedge clk_i);
		res_ready_i = 1'b0;
	endtask

	task run(input logic [7:0] op, input logic [7:0] a, input int nres);
		logic [7:0] d;
		m.loc_q = {};
		send(op);
		if (op == 8'h32 || op == 8'h33)
			send(a);
		if (op == 8'h33)
			foreach (wq[n]) send(wq[n]);
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		rq = {};
		repeat (nres) begin
			get(d);
			rq.push_back(d);
		end
	endtask

	function automatic logic [18:0] loc(input int v, input int b, input int c);
		if (v == 0)
			return {8'(c), 3'(b / 20), 8'(b % 20)};
		if (v == 1)
			return {8'(c * 2 + b / 18), 3'h0, 8'(b % 18)};
		return {8'h01, 3'h0, 8'(b == 0 ? c : b + 2)};
	endfunction

	// ==========================================
	// main sequence
	initial begin
		{fails, num_checks} = '0;
		{rst_n_i, prep_mode_i, cmd_valid_i, res_ready_i} = '0;
		{variant_i, cmd_data_i} = '0;
		raw_blocks_i = 24'h00_8000;
		k = $urandom(38);
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b1;
		for (v = 0; v < 3; v++) begin
			variant_i = 2'(v);
			raw_blocks_i = 24'h00_1000 + 24'($urandom_range(0, 4095));
			prep_mode_i = 1'b1;
			repeat (6) @(negedge clk_i);
			check(usable_blocks_o, raw_blocks_i - rsv[v]);
			check(user_first_trk_o, fst[v]);
			check(med_raw_o, 1'b1);
			for (j = 0; j < 2; j++) begin
				// boundary block first, last block second
				b = (j == 1) ? (v == 0 ? 39 : 35) : (v == 0 ? 20 : v == 1 ? 18 : 0);
				adr = (v == 0) ? {3'(b / 20), 5'(b % 20)} : 8'(b);
				wq = {};
				repeat (512) wq.push_back(8'($urandom));
				run(8'h33, adr, 1);
				check(rq[0], 8'h00);
				nc = (v < 2) ? 2 : (b == 0 ? 3 : 1);
				check(24'(m.loc_q.size()), 24'(nc));
				foreach (m.loc_q[n]) check(m.loc_q[n], loc(v, b, n));
				run(8'h32, adr, 513);
				check(m.loc_q[0], loc(v, b, 0));
				check(rq[0], 8'h00);
				for (i = 0; i < 512; i++) check(rq[i + 1], wq[i]);
			end
			run(8'h32, (v == 0) ? 8'h34 : 8'h24, 513);
			check(rq[0], 8'h82);
			check(rq[512], 8'h00);
			check(24'(m.loc_q.size()), 24'h00_0000);
		end
		// illegal strap: every firmware address is refused
		@(negedge clk_i);
		variant_i = 2'b11;
		repeat (6) @(negedge clk_i);
		run(8'h32, 8'h00, 513);
		check(rq[0], 8'h82);
		check(24'(m.loc_q.size()), 24'h00_0000);
		variant_i = 2'b10;
		@(negedge clk_i);
		prep_mode_i = 1'b0;
		run(8'h32, 8'h00, 513);
		check(rq[0], 8'h81);
		run(8'h33, 8'h00, 1);
		check(rq[0], 8'h81);
		check(24'(m.loc_q.size()), 24'h00_0000);
		run(8'h35, 8'h00, 1);
		check(rq[0], 8'h84);
		@(negedge clk_i);
		prep_mode_i = 1'b1;
		m.err_on = 1'b1;
		run(8'h33, 8'h01, 1);
		check(rq[0], 8'h83);
		finish_test();
	end
endmodule
